//--- rtl/rfb_rate_buffer.sv
// The implementer's own choices: the register addresses and the AXI4-Lite slave port.
`timescale 1ns/1ps
module rfb_rate_buffer
    import rfb_pkg::*;
(
    input  wire logic        clock,
    input  wire logic        sys_rst,
    input  wire logic [31:0] s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [31:0] s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    input  wire rfb_word_type ioWordIn,
    output logic             ioDataRequest,
    output rfb_byte_type     ioByteOut,
    input  wire logic        ioByteTaken,
    input  wire logic        preambleFound,
    input  wire logic [7:0]  discByteIn,
    output rfb_byte_type     discByteOut,
    output logic             rateError
);

    typedef struct packed {
        logic [7:0]        ctrl;
        logic              awHeld;
        logic [7:0]        awAddr;
        logic              wHeld;
        logic [31:0]       wData;
        logic [3:0]        wStrb;
        logic              awReady;
        logic              wReady;
        logic              bValid;
        logic [1:0]        bResp;
        logic              arReady;
        logic              rValid;
        logic [31:0]       rData;
        logic [1:0]        rResp;
        logic              transferPhase;
        logic              ioReq;
        logic [1:0]        ifTimer;
        logic              ifRunning;
        logic [31:0]       inReg;
        logic [7:0]        writeStage;
        logic              writeStageFull;
        logic [7:0]        outStage;
        logic              outStageFull;
        logic [ADDR_W-1:0] wrPtr;
        logic [ADDR_W-1:0] rdPtr;
        logic [ADDR_W-1:0] addrLatch;
        logic [4:0]        space;
        logic [1:0]        byteCount;
        rfb_cycle_type     cyc;
        logic              cycRead;
        logic [3:0]        bitDiv;
        logic [2:0]        bitCnt;
        rfb_byte_type      discOut;
        rfb_byte_type      ioOut;
        logic              rateErr;
    } rfb_state_type;

    rfb_state_type state_ff;
    rfb_state_type nxt_state;
    logic [7:0]    memRdData;
    logic          memWe;

    // Stage release: last byte of the word is being written into the buffer.
    function automatic logic stageRelease(input logic multi, input logic four,
                                          input logic [1:0] cnt);
        stageRelease = !multi || (!four && !cnt[0]) || (four && !cnt[1] && !cnt[0]);
    endfunction

    // Pointer step with wrap at the buffer depth.
    function automatic logic [ADDR_W-1:0] ptrStep(input logic [ADDR_W-1:0] ptr);
        ptrStep = ptr + 4'h1;
    endfunction

    logic enable;
    logic readMode;
    logic multiByte;
    logic fourByte;
    logic fifoEmptyFlag;
    logic fifoSpaceFlag;
    logic fifoReadAllow;
    logic byteTick;
    logic startRead;
    logic startWrite;
    logic readOrderReadCycle;
    logic outLoadEnable;
    logic [31:0] statusWord;

    // Mode bits and flags decoded from state.
    always_comb begin
        enable        = state_ff.ctrl[CTRL_ENABLE_BIT];
        readMode      = state_ff.ctrl[CTRL_READ_BIT];
        multiByte     = state_ff.ctrl[CTRL_MULTI_BIT];
        fourByte      = state_ff.ctrl[CTRL_FOUR_BIT] && multiByte;
        fifoEmptyFlag = (state_ff.space == SPACE_RESET);
        fifoSpaceFlag = (state_ff.space != 5'h00);
        fifoReadAllow = readMode || (state_ff.ctrl[CTRL_PREDONE_BIT]
                                     && !state_ff.ctrl[CTRL_POSTAMBLE_FLAG_BIT]);
        byteTick      = (state_ff.bitDiv == 4'(BIT_CYCLES - 1))
                        && (state_ff.bitCnt == BYTE_LAST_BIT);
        readOrderReadCycle = readMode && state_ff.cycRead
                             && (state_ff.cyc != CYC_IDLE);
        outLoadEnable = !readOrderReadCycle || !multiByte
                        || (state_ff.byteCount == COUNT_TOP);
        startRead     = enable && fifoReadAllow && !state_ff.outStageFull
                        && !fifoEmptyFlag && (state_ff.cyc == CYC_IDLE);
        startWrite    = enable && state_ff.writeStageFull && fifoSpaceFlag
                        && (state_ff.cyc == CYC_IDLE);
        statusWord    = '0;
        statusWord[STAT_WSFULL_BIT] = state_ff.writeStageFull;
        statusWord[STAT_OSFULL_BIT] = state_ff.outStageFull;
        statusWord[STAT_EMPTY_BIT]  = fifoEmptyFlag;
        statusWord[STAT_SPACE_BIT]  = fifoSpaceFlag;
        statusWord[STAT_RATE_BIT]   = state_ff.rateErr;
        statusWord[STAT_PHASE_BIT]  = state_ff.transferPhase;
        statusWord[STAT_OCC_LSB +: 5] = SPACE_RESET - state_ff.space;
    end

    // Buffer memory is driven from the address latch during the move step.
    assign memWe = (state_ff.cyc == CYC_MOVE) && !state_ff.cycRead;

    rfb_memory u_memory (
        .clock       (clock),
        .writeEnable (memWe),
        .address     (state_ff.addrLatch),
        .writeData   (state_ff.writeStage),
        .readData    (memRdData)
    );

    // Next-state logic for the bus slave and the buffer datapath.
    always_comb begin
        logic wrDo;
        logic clrRate;
        logic setRate;
        wrDo      = 1'b0;
        clrRate   = 1'b0;
        setRate   = 1'b0;
        nxt_state = state_ff;

        // Write address and data are taken independently, answered when both are held.
        if (s_axi_awvalid && state_ff.awReady) begin
            nxt_state.awHeld = 1'b1;
            nxt_state.awAddr = s_axi_awaddr[7:0];
        end
        if (s_axi_wvalid && state_ff.wReady) begin
            nxt_state.wHeld = 1'b1;
            nxt_state.wData = s_axi_wdata;
            nxt_state.wStrb = s_axi_wstrb;
        end
        if (state_ff.bValid && s_axi_bready) begin
            nxt_state.bValid = 1'b0;
        end
        if (state_ff.awHeld && state_ff.wHeld && !state_ff.bValid) begin
            wrDo             = 1'b1;
            nxt_state.awHeld = 1'b0;
            nxt_state.wHeld  = 1'b0;
            nxt_state.bValid = 1'b1;
            nxt_state.bResp  = RESP_DECERR;
            if (state_ff.awAddr == CTRL_OFFSET) begin
                nxt_state.bResp = RESP_OKAY;
                if (state_ff.wStrb[0]) begin
                    nxt_state.ctrl = state_ff.wData[7:0];
                end
            end else if (state_ff.awAddr == STATUS_OFFSET) begin
                nxt_state.bResp = RESP_OKAY;
                clrRate = state_ff.wStrb[0] && state_ff.wData[STAT_RATE_BIT];
            end
        end
        nxt_state.awReady = !nxt_state.awHeld && !nxt_state.bValid && !wrDo;
        nxt_state.wReady  = !nxt_state.wHeld && !nxt_state.bValid && !wrDo;

        // Reads answer one cycle after the address is taken.
        if (state_ff.rValid && s_axi_rready) begin
            nxt_state.rValid = 1'b0;
        end
        if (s_axi_arvalid && state_ff.arReady) begin
            nxt_state.rValid = 1'b1;
            nxt_state.rResp  = RESP_OKAY;
            if (s_axi_araddr[7:0] == CTRL_OFFSET) begin
                nxt_state.rData = {24'h000000, state_ff.ctrl};
            end else if (s_axi_araddr[7:0] == STATUS_OFFSET) begin
                nxt_state.rData = statusWord;
            end else begin
                nxt_state.rData = 32'h00000000;
                nxt_state.rResp = RESP_DECERR;
            end
        end
        nxt_state.arReady = !nxt_state.rValid;

        // Bit-time divider; one byte time is eight bit times.
        if (state_ff.bitDiv == 4'(BIT_CYCLES - 1)) begin
            nxt_state.bitDiv = 4'h0;
            nxt_state.bitCnt = state_ff.bitCnt + 3'h1;
        end else begin
            nxt_state.bitDiv = state_ff.bitDiv + 4'h1;
        end
        nxt_state.discOut.valid = 1'b0;

        // Processor word accepted in the request phase starts the interface cycle timer.
        if (enable && !readMode && !state_ff.transferPhase && ioWordIn.valid
            && state_ff.ioReq) begin
            nxt_state.inReg         = ioWordIn.data;
            nxt_state.transferPhase = 1'b1;
            nxt_state.ifRunning     = 1'b1;
            nxt_state.ifTimer       = 2'(IF_CYCLES - 1);
        end else if (state_ff.ifRunning) begin
            if (state_ff.ifTimer == 2'h0) begin
                // Input load pulse: top lane into the write stage, counter preset.
                nxt_state.ifRunning      = 1'b0;
                nxt_state.writeStage     = state_ff.inReg[31:24];
                nxt_state.writeStageFull = 1'b1;
                nxt_state.byteCount      = COUNT_TOP;
            end else begin
                nxt_state.ifTimer = state_ff.ifTimer - 2'h1;
            end
        end

        // Disc side: at most one byte each byte time, in or out according to direction.
        if (enable && byteTick) begin
            if (readMode) begin
                if (preambleFound) begin
                    if (state_ff.writeStageFull) begin
                        setRate = 1'b1;
                    end else begin
                        nxt_state.writeStage     = discByteIn;
                        nxt_state.writeStageFull = 1'b1;
                    end
                end
            end else if (fifoReadAllow) begin
                if (state_ff.outStageFull) begin
                    nxt_state.discOut.data  = state_ff.outStage;
                    nxt_state.discOut.valid = 1'b1;
                    nxt_state.outStageFull  = 1'b0;
                end else begin
                    setRate = 1'b1;
                end
            end
        end

        // Disc read: the processor takes bytes out of the output stage.
        if (state_ff.ioOut.valid && ioByteTaken) begin
            nxt_state.ioOut.valid = 1'b0;
        end
        if (readMode && state_ff.outStageFull && !state_ff.ioOut.valid) begin
            nxt_state.ioOut.data   = state_ff.outStage;
            nxt_state.ioOut.valid  = 1'b1;
            nxt_state.outStageFull = 1'b0;
        end

        // Buffer cycle sequencer; one cycle type is granted at its start.
        case (state_ff.cyc)
            CYC_IDLE: begin
                if (!readMode && startRead) begin
                    nxt_state.cyc     = CYC_CLR;
                    nxt_state.cycRead = 1'b1;
                end else if (startWrite) begin
                    nxt_state.cyc     = CYC_CLR;
                    nxt_state.cycRead = 1'b0;
                end else if (startRead && outLoadEnable) begin
                    nxt_state.cyc     = CYC_CLR;
                    nxt_state.cycRead = 1'b1;
                end
            end
            CYC_CLR: begin
                nxt_state.addrLatch = '0;
                nxt_state.cyc       = CYC_ADDR;
            end
            CYC_ADDR: begin
                nxt_state.addrLatch = state_ff.cycRead ? state_ff.rdPtr
                                                       : state_ff.wrPtr;
                nxt_state.cyc       = CYC_MOVE;
            end
            CYC_MOVE: begin
                nxt_state.cyc = CYC_ADV;
            end
            CYC_ADV: begin
                nxt_state.cyc = CYC_IDLE;
                if (state_ff.cycRead) begin
                    nxt_state.outStage     = memRdData;
                    nxt_state.outStageFull = 1'b1;
                    nxt_state.rdPtr        = ptrStep(state_ff.rdPtr);
                    nxt_state.space        = state_ff.space + 5'h01;
                end else begin
                    nxt_state.wrPtr = ptrStep(state_ff.wrPtr);
                    nxt_state.space = state_ff.space - 5'h01;
                    if (readMode || stageRelease(multiByte, fourByte, state_ff.byteCount)) begin
                        nxt_state.writeStageFull = 1'b0;
                    end else begin
                        nxt_state.writeStage = state_ff.inReg[23:16];
                        nxt_state.inReg      = {state_ff.inReg[23:0], 8'h00};
                    end
                    if (multiByte) begin
                        nxt_state.byteCount = state_ff.byteCount - 2'h1;
                    end
                end
            end
            default: begin
                nxt_state.cyc = CYC_IDLE;
            end
        endcase

        // Back to the request phase only once the write stage is empty.
        if (state_ff.transferPhase && !state_ff.writeStageFull && !state_ff.ifRunning
            && !nxt_state.writeStageFull) begin
            nxt_state.transferPhase = 1'b0;
        end
        nxt_state.ioReq = enable && !readMode && !nxt_state.transferPhase
                          && !nxt_state.writeStageFull;

        // Rate error is sticky; a new error wins over a software clear.
        if (setRate) begin
            nxt_state.rateErr = 1'b1;
        end else if (clrRate) begin
            nxt_state.rateErr = 1'b0;
        end
        if (!enable) begin
            nxt_state.writeStageFull = 1'b0;
            nxt_state.outStageFull   = 1'b0;
            nxt_state.transferPhase  = 1'b0;
            nxt_state.ifRunning      = 1'b0;
            nxt_state.ioReq          = 1'b0;
            if (state_ff.cyc == CYC_IDLE) begin
                nxt_state.wrPtr = '0;
                nxt_state.rdPtr = '0;
                nxt_state.space = SPACE_RESET;
            end
        end
    end

    // State register with synchronous reset.
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            state_ff       <= '0;
            state_ff.ctrl  <= CTRL_RESET;
            state_ff.space <= SPACE_RESET;
            state_ff.cyc   <= CYC_IDLE;
        end else begin
            state_ff <= nxt_state;
        end
    end

    // Outputs come straight from the state register.
    assign s_axi_awready = state_ff.awReady;
    assign s_axi_wready  = state_ff.wReady;
    assign s_axi_bvalid  = state_ff.bValid;
    assign s_axi_bresp   = state_ff.bResp;
    assign s_axi_arready = state_ff.arReady;
    assign s_axi_rvalid  = state_ff.rValid;
    assign s_axi_rdata   = state_ff.rData;
    assign s_axi_rresp   = state_ff.rResp;
    assign ioDataRequest = state_ff.ioReq;
    assign ioByteOut     = state_ff.ioOut;
    assign discByteOut   = state_ff.discOut;
    assign rateError     = state_ff.rateErr;

endmodule

//--- rtl/rfb_pkg.sv
package rfb_pkg;

    // Clock and timing.
    localparam int unsigned CLK_PERIOD_NS = 20;
    localparam int unsigned BIT_TIME_NS   = 200;
    localparam int unsigned BIT_CYCLES    = (BIT_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned IF_CYCLE_NS   = 60;
    localparam int unsigned IF_CYCLES     = (IF_CYCLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [2:0]  BYTE_LAST_BIT = 3'h7;

    // Buffer geometry.
    localparam int unsigned FIFO_DEPTH  = 16;
    localparam int unsigned ADDR_W      = 4;
    localparam logic [4:0]  SPACE_RESET = 5'h10;
    localparam logic [1:0]  COUNT_TOP   = 2'h3;

    // Register offsets (byte addresses) and control reset value.
    localparam logic [7:0] CTRL_OFFSET   = 8'h00;
    localparam logic [7:0] STATUS_OFFSET = 8'h04;
    localparam logic [7:0] CTRL_RESET    = 8'h00;

    // Control field positions.
    localparam int unsigned CTRL_ENABLE_BIT  = 0;
    localparam int unsigned CTRL_READ_BIT    = 1;
    localparam int unsigned CTRL_MULTI_BIT   = 2;
    localparam int unsigned CTRL_FOUR_BIT    = 3;
    localparam int unsigned CTRL_PREDONE_BIT = 4;
    localparam int unsigned CTRL_POSTAMBLE_FLAG_BIT    = 5;

    // Status field positions.
    localparam int unsigned STAT_WSFULL_BIT = 0;
    localparam int unsigned STAT_OSFULL_BIT = 1;
    localparam int unsigned STAT_EMPTY_BIT  = 2;
    localparam int unsigned STAT_SPACE_BIT  = 3;
    localparam int unsigned STAT_RATE_BIT   = 4;
    localparam int unsigned STAT_PHASE_BIT  = 5;
    localparam int unsigned STAT_OCC_LSB    = 8;

    // Bus responses.
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_DECERR = 2'h3;

    // Buffer cycle sequencer steps.
    typedef enum logic [4:0] {
        CYC_IDLE = 5'b00001,
        CYC_CLR  = 5'b00010,
        CYC_ADDR = 5'b00100,
        CYC_MOVE = 5'b01000,
        CYC_ADV  = 5'b10000
    } rfb_cycle_type;

    // Processor-side write stream.
    typedef struct packed {
        logic        valid;
        logic [31:0] data;
    } rfb_word_type;

    // Byte moving on the disc or processor side.
    typedef struct packed {
        logic       valid;
        logic [7:0] data;
    } rfb_byte_type;

endpackage

//--- rtl/rfb_memory.sv
`timescale 1ns/1ps
module rfb_memory
    import rfb_pkg::*;
(
    input  wire logic              clock,
    input  wire logic              writeEnable,
    input  wire logic [ADDR_W-1:0] address,
    input  wire logic [7:0]        writeData,
    output logic      [7:0]        readData
);

    logic [7:0] memArray [FIFO_DEPTH];

    // One port: a write stores the byte, the read data are registered each cycle.
    always_ff @(posedge clock) begin
        if (writeEnable) begin
            memArray[address] <= writeData;
        end
        readData <= memArray[address];
    end

endmodule

//--- testbench/rfb_checker_sva.sv
`timescale 1ns/1ps
module rfb_checker
    import rfb_pkg::*;
(
    input wire logic         clock, sys_rst, s_axi_awvalid, s_axi_awready, s_axi_wvalid,
    input wire logic         s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid,
    input wire logic         s_axi_arready, s_axi_rvalid, s_axi_rready, ioDataRequest,
    input wire logic         ioByteTaken, rateError,
    input wire logic [31:0]  s_axi_rdata,
    input wire rfb_word_type ioWordIn,
    input wire rfb_byte_type ioByteOut, discByteOut
);
    default clocking @(posedge clock); endclocking
    default disable iff (sys_rst);
    // A word taken, a write address and data taken together, a disc byte sent.
    sequence s_take; ioWordIn.valid && ioDataRequest; endsequence
    sequence s_wr; s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready; endsequence
    sequence s_disc; discByteOut.valid; endsequence
    property p_req_drop; s_take |=> !ioDataRequest [*7]; endproperty
    a_req_drop: assert property (p_req_drop) else $error("request stayed up");
    property p_disc_gap; s_disc |=> !discByteOut.valid [*8]; endproperty
    a_disc_gap: assert property (p_disc_gap) else $error("disc bytes too close");
    property p_rate_sticky; rateError && s_axi_awready && !s_axi_wvalid |=> rateError; endproperty
    a_rate_sticky: assert property (p_rate_sticky) else $error("rate error lost");
    property p_b_late; s_wr |=> ##1 s_axi_bvalid; endproperty
    a_b_late: assert property (p_b_late) else $error("write answer late");
    property p_b_hold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid; endproperty
    a_b_hold: assert property (p_b_hold) else $error("write answer dropped");
    property p_r_late; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
    a_r_late: assert property (p_r_late) else $error("read answer late");
    property p_r_hold; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
    endproperty
    a_r_hold: assert property (p_r_hold) else $error("read answer changed");
    property p_io_hold;
        ioByteOut.valid && !ioByteTaken |=> ioByteOut.valid && $stable(ioByteOut.data);
    endproperty
    a_io_hold: assert property (p_io_hold) else $error("processor byte changed");
endmodule
bind rfb_rate_buffer rfb_checker rfb_checker_i (.clock(clock), .sys_rst(sys_rst),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .ioDataRequest(ioDataRequest), .ioByteTaken(ioByteTaken),
    .rateError(rateError), .s_axi_rdata(s_axi_rdata), .ioWordIn(ioWordIn),
    .ioByteOut(ioByteOut), .discByteOut(discByteOut));

//--- testbench/rfb_io_partner.sv
`timescale 1ns/1ps
module rfb_io_partner
    import rfb_pkg::*;
(
    input  wire logic         clock,
    input  wire logic         sys_rst,
    input  wire logic         stall,
    input  wire logic [31:0]  nextWord,
    input  wire logic         ioDataRequest,
    input  wire rfb_byte_type ioByteOut,
    output rfb_word_type      ioWordIn,
    output logic              ioByteTaken
);
    // Offers a word only while asked and holds it until taken; idle data keeps changing.
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            ioWordIn    <= '0;
            ioByteTaken <= 1'b0;
        end else begin
            if (ioWordIn.valid && ioDataRequest) begin
                ioWordIn <= {1'b0, ~ioWordIn.data};
            end else if (!ioWordIn.valid) begin
                ioWordIn <= (ioDataRequest && !stall) ? {1'b1, nextWord}
                                                      : {1'b0, ~ioWordIn.data};
            end
            ioByteTaken <= ioByteOut.valid && !ioByteTaken; // Takes every second cycle.
        end
    end
endmodule

//--- testbench/rfb_rate_buffer_tb.sv
`timescale 1ns/1ps
module rfb_rate_buffer_tb;
    import rfb_pkg::*;
    logic         clock = 1'b0, sys_rst = 1'b1, stall = 1'b1, preambleFound = 1'b0;
    logic [31:0]  s_axi_awaddr = '0, s_axi_wdata = '0, s_axi_araddr = '0, nextWord, rd;
    logic [3:0]   s_axi_wstrb = '0;
    logic         s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic         s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic         s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0]   s_axi_bresp, s_axi_rresp, rs;
    logic [31:0]  s_axi_rdata;
    logic         ioDataRequest, ioByteTaken, rateError;
    logic [7:0]   discByteIn = 8'h5a;
    rfb_word_type ioWordIn;
    rfb_byte_type ioByteOut, discByteOut;
    logic [15:0]  lfsr = 16'h0011;
    logic [7:0]   q[$];
    logic [7:0]   modes[3] = '{8'h01, 8'h05, 8'h0d};
    int           error_cnt = 0, check_count = 0, pulses = 0, ioCount = 0, nb = 1;
    rfb_rate_buffer rfb_rate_buffer_i (.*);
    rfb_io_partner  rfb_io_partner_i (.*);
    assign nextWord = {lfsr, ~lfsr};
    always #10 clock = ~clock;
    function automatic logic [15:0] lfsrNext(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    always @(posedge clock) lfsr <= lfsrNext(lfsr);
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic axiWrite(input logic [7:0] a, input logic [31:0] d);
        @(posedge clock);
        s_axi_awaddr <= {24'h0, a};
        s_axi_wdata <= d;
        s_axi_wstrb <= 4'hf;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge clock);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (!s_axi_bvalid);
        rs = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask
    task automatic axiRead(input logic [7:0] a);
        @(posedge clock);
        s_axi_araddr <= {24'h0, a};
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge clock);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (!s_axi_rvalid);
        rd = s_axi_rdata;
        rs = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask
    task automatic final_report();
        $display("checks %0d mismatches %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    // Notes the first nb bytes of each taken word, top lane first.
    always @(posedge clock) begin
        if (ioWordIn.valid && ioDataRequest)
            for (int i = 0; i < nb; i++) q.push_back(ioWordIn.data[31-8*i -: 8]);
    end
    // Compares every disc byte with the oldest note and every processor byte with the disc value.
    always @(posedge clock) begin
        if (!sys_rst && discByteOut.valid) begin
            pulses++;
            chk({24'h0, discByteOut.data}, q.size() ? {24'h0, q.pop_front()} : '1);
        end
        if (ioByteOut.valid && ioByteTaken) begin
            ioCount++;
            chk({24'h0, ioByteOut.data}, 32'h5a);
        end
    end
    // Stops a hung run.
    initial begin
        repeat (20000) @(posedge clock);
        error_cnt++;
        final_report();
    end
    initial begin
        repeat (12) @(posedge clock);
        sys_rst <= 1'b0;
        axiRead(CTRL_OFFSET);
        chk(rd, 32'h0);
        axiRead(STATUS_OFFSET);
        chk(rd & 32'h1f1f, 32'h000c);
        axiRead(8'h08);
        chk({30'h0, rs}, 32'h3);
        axiWrite(8'h08, 32'h1);
        chk({30'h0, rs}, 32'h3);
        $display("test registers done");
        foreach (modes[m]) begin
            nb = 1 << m;
            axiWrite(CTRL_OFFSET, {24'h0, modes[m]});
            stall <= 1'b0;
            repeat (400) @(posedge clock);
            chk(pulses, 0);
            chk({31'h0, ioDataRequest}, 32'h0);
            axiRead(STATUS_OFFSET);
            chk(rd & 32'h1f1f, 32'h1001);
            axiWrite(CTRL_OFFSET, {24'h0, modes[m] | 8'h30});
            repeat (200) @(posedge clock);
            chk(pulses, 0);
            stall <= 1'b1;
            axiWrite(CTRL_OFFSET, {24'h0, modes[m] | 8'h10});
            for (int t = 0; t < 4000 && (q.size() != 0 || !rateError); t++) @(posedge clock);
            chk(q.size(), 0);
            axiRead(STATUS_OFFSET);
            chk(rd & 32'h1f1f, 32'h001c);
            axiWrite(CTRL_OFFSET, 32'h0);
            axiWrite(STATUS_OFFSET, 32'h10);
            axiRead(STATUS_OFFSET);
            chk(rd & 32'h1f1f, 32'h000c);
            pulses = 0;
            $display("test mode %h done", modes[m]);
        end
        axiWrite(CTRL_OFFSET, 32'h3);
        preambleFound <= 1'b1;
        repeat (400) @(posedge clock);
        preambleFound <= 1'b0;
        chk({31'h0, ioCount > 3}, 32'h1);
        chk({31'h0, rateError}, 32'h0);
        $display("test disc read done");
        final_report();
    end
endmodule
